/* logic/msf_top.sv */
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "msf_cfg.svh"

// What this block does
// - Queue mode 00 off, 01 stop when full, 10 or 11 overwrite oldest.
// - Enabled queue holds up to 32 entries of temperature plus pressure.
// - Temperature select 0 stores first temperature channel, else the second.
// - With all three channels disabled nothing is written; queue stays empty.
// - Disabled channel slots reuse that channel's latest valid earlier result.
// - Raw mode stores 24-bit converter word, error code unless diagnostic masked.
// - Compensated mode stores 22 bits plus two zero bits, or full filtered 24.
// - Compensated values are replaced by diagnostic codes when unmasked.
// - Queue off holds both pointers at zero and suppresses error codes.
// - Stop-when-full mode drops new results once all entries are occupied.
// - Overwrite mode advances both pointers when full and a new entry arrives.
// - Five-bit threshold, 0 disables, 1 to 31 samples trigger the event.
// - Threshold event when write pointer leads read pointer by threshold count.
// - Empty and full flags change only at conversion completion.
// - Storage continues past threshold until the queue is full.
// - Sample-read returns entry at read pointer and increments it at once.
// - A full queue gives 32 reads in stop mode, 31 in overwrite mode.
// - Channel, ratio and mask writes are refused while automatic mode runs.
// - Automatic mode runs whenever the four-bit delay field is nonzero.
// - Each channel converts every N cycles; stale temperature completes the pair.
// - Compensation starts after every automatic cycle with a conversion.
// - Empty, full and threshold are separate status flags beside done.
module msf_top #(
  parameter int DEPTH = `MSF_DEPTH
)(
  input  wire logic                    ref_clk,
  input  wire logic                    rstn,
  input  wire logic [7:0]              reg_addr,
  input  wire logic [15:0]             reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [15:0]             reg_rdata,
  input  wire logic                    cycle_tick,
  input  wire logic                    conv_done,
  input  wire logic [2:0]              res_valid,
  input  wire msf_pkg::msf_word_t [2:0] res_raw,
  input  wire msf_pkg::msf_word_t [2:0] res_cmp,
  input  wire logic [2:0][2:0]         res_err,
  output logic      [2:0]              conv_req,
  output logic                         comp_start
);

  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] CAP_STOP = (PW+1)'(DEPTH);
  localparam logic [PW:0] CAP_OVWR = (PW+1)'(DEPTH - 1);

  typedef struct packed
  {
    logic [15:0]                operation_control;
    logic [15:0]                chan;
    logic [15:0]                ratio;
    logic [15:0]                mask;
    logic [PW-1:0]              rd_ptr;
    logic [PW-1:0]              wr_ptr;
    logic [PW:0]                cnt;
    logic [2:0][3:0]            rcnt;
    msf_pkg::msf_word_t [2:0]   last;
    logic [47:0]                hold;
    logic [15:0]                rdata;
    logic                       f_done;
    logic                       f_thr;
    logic                       f_empty;
    logic                       f_full;
    logic [2:0]                 req;
    logic                       comp;
  } msf_state_t;

  localparam msf_state_t RST = '{
    operation_control    : `MSF_RST_OPERATION_CONTROL,
    chan    : `MSF_RST_CHAN,
    ratio   : `MSF_RST_RATIO,
    mask    : `MSF_RST_MASK,
    f_empty : 1'b1,
    default : '0
  };

  msf_state_t                s;
  msf_state_t                next_s;
  msf_pkg::msf_qmode_t       qmode;
  logic                      q_on;
  logic                      q_stop;
  logic                      q_ovwr;
  logic                      auto_on;
  logic [2:0]                ch_off;
  logic [4:0]                thr;
  logic [2:0]                ch_fresh;
  msf_pkg::msf_word_t [2:0]  ch_word;
  msf_pkg::msf_word_t [2:0]  ch_next;
  msf_pkg::msf_word_t        t_sel;
  logic                      any_conv;
  logic                      pop;
  logic                      pop_ok;
  logic                      wr_ok;
  logic                      over;
  logic [47:0]               pop_word;

  msf_if #(.AW(PW), .DW(`MSF_ENTRY_W)) mif ();

  msf_store #(.DEPTH(DEPTH), .DW(`MSF_ENTRY_W)) u_store
  (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .port    (mif.mem)
  );

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  function automatic msf_pkg::msf_qmode_t decode_mode(input logic [1:0] m);
    msf_pkg::msf_qmode_t r;
    unique case (m)
      2'b00:        r = msf_pkg::MSF_Q_OFF;
      2'b01:        r = msf_pkg::MSF_Q_STOP;
      2'b10, 2'b11: r = msf_pkg::MSF_Q_OVWR;
    endcase
    return r;
  endfunction

  assign qmode   = decode_mode(s.operation_control[`MSF_OPERATION_CONTROL_MODE +: 2]);
  assign q_on    = (qmode != msf_pkg::MSF_Q_OFF);
  assign q_stop  = (qmode == msf_pkg::MSF_Q_STOP);
  assign q_ovwr  = (qmode == msf_pkg::MSF_Q_OVWR);
  assign auto_on = (s.operation_control[`MSF_OPERATION_CONTROL_DLY +: 4] != 4'h0);
  assign thr     = s.operation_control[`MSF_OPERATION_CONTROL_THR +: 5];
  assign ch_off  = s.chan[2:0];

  // ----------------------------------------
  // Per-channel sample formatting
  // ----------------------------------------
  for (genvar c = 0; c < 3; c++)
  begin : g_ch
    logic [2:0]         hit;
    msf_pkg::msf_word_t base;
    msf_pkg::msf_word_t code;
    // Bits: bridge, overflow, underflow; a set mask bit hides one
    assign hit  = res_err[c] & ~s.mask[3*c +: 3];
    assign base = s.chan[`MSF_CHAN_RAW] ? res_raw[c] :
                  (s.chan[`MSF_CHAN_IIR] ? res_cmp[c] :
                   {res_cmp[c][23:2], 2'b00});
    assign code = hit[0] ? `MSF_ERR_BRIDGE :
                  (hit[1] ? `MSF_ERR_OVFL : `MSF_ERR_UDFL);
    // Codes only while the queue is on
    assign ch_word[c]  = (q_on && (|hit)) ? code : base;
    assign ch_fresh[c] = res_valid[c] && !ch_off[c];
    assign ch_next[c]  = ch_fresh[c] ? ch_word[c] : s.last[c];
  end

  assign t_sel    = s.operation_control[`MSF_OPERATION_CONTROL_SELT] ? ch_next[2] : ch_next[1];
  // All channels off leaves ch_fresh empty, so nothing is stored
  assign any_conv = conv_done && (|ch_fresh);

  // ----------------------------------------
  // Queue pointer control
  // ----------------------------------------
  assign pop    = reg_rd && (reg_addr == `MSF_OFF_POP);
  assign pop_ok = q_on && pop && (s.cnt != '0);
  // Threshold never gates the write; only the capacity does
  assign wr_ok  = q_on && any_conv && !(q_stop && s.cnt >= CAP_STOP);
  // One slot is sacrificed so the two pointers never meet
  assign over   = wr_ok && q_ovwr && (s.cnt >= CAP_OVWR) && !pop_ok;

  assign mif.wr_en   = wr_ok;
  assign mif.wr_addr = s.wr_ptr;
  assign mif.wr_data = {t_sel, ch_next[0]};
  assign mif.rd_addr = s.rd_ptr;

  // Off mode answers with the latest pair, free of error codes
  assign pop_word = !q_on ? {s.operation_control[`MSF_OPERATION_CONTROL_SELT] ? s.last[2] : s.last[1], s.last[0]} :
                    ((s.cnt != '0) ? mif.rd_data : 48'h000000000000);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    next_s       = s;
    next_s.req   = 3'h0;
    next_s.comp  = 1'b0;
    next_s.rdata = 16'h0000;

    if (reg_wr)
    begin
      case (reg_addr)
        `MSF_OFF_OPERATION_CONTROL:
        begin
          next_s.operation_control = reg_wdata;
        end
        `MSF_OFF_CHAN:
        begin
          if (!auto_on)
          begin
            next_s.chan = reg_wdata;
          end
        end
        `MSF_OFF_RATIO:
        begin
          if (!auto_on)
          begin
            next_s.ratio = reg_wdata;
          end
        end
        `MSF_OFF_MASK:
        begin
          if (!auto_on)
          begin
            next_s.mask = reg_wdata;
          end
        end
        `MSF_OFF_STAT:
        begin
          // Write one to clear; a same-cycle event sets it again below
          if (reg_wdata[`MSF_STAT_DONE])
          begin
            next_s.f_done = 1'b0;
          end
          if (reg_wdata[`MSF_STAT_THR])
          begin
            next_s.f_thr = 1'b0;
          end
        end
        default:
        begin
        end
      endcase
    end

    // Ratio counters: a channel converts on the tick where its count is 0
    for (int c = 0; c < 3; c++)
    begin
      if (!auto_on)
      begin
        next_s.rcnt[c] = 4'h0;
      end
      else if (cycle_tick)
      begin
        next_s.req[c] = !ch_off[c] && (s.rcnt[c] == 4'h0);
        if (s.ratio[4*c +: 4] <= 4'h1 || s.rcnt[c] >= s.ratio[4*c +: 4] - 4'h1)
        begin
          next_s.rcnt[c] = 4'h0;
        end
        else
        begin
          next_s.rcnt[c] = s.rcnt[c] + 4'h1;
        end
      end
    end

    if (conv_done)
    begin
      next_s.last = ch_next;
    end
    next_s.comp = any_conv && auto_on;

    if (!q_on)
    begin
      next_s.rd_ptr = '0;
      next_s.wr_ptr = '0;
      next_s.cnt    = '0;
    end
    else
    begin
      if (wr_ok)
      begin
        next_s.wr_ptr = s.wr_ptr + PW'(1);
      end
      if (pop_ok || over)
      begin
        next_s.rd_ptr = s.rd_ptr + PW'(1);
      end
      next_s.cnt = s.cnt + (PW+1)'(wr_ok && !over) - (PW+1)'(pop_ok);
    end

    if (conv_done)
    begin
      next_s.f_done  = 1'b1;
      next_s.f_empty = (next_s.cnt == '0);
      next_s.f_full  = q_on && (next_s.cnt == (q_ovwr ? CAP_OVWR : CAP_STOP));
      if (thr != 5'h00 && next_s.cnt >= (PW+1)'(thr))
      begin
        next_s.f_thr = 1'b1;
      end
    end

    if (reg_rd)
    begin
      case (reg_addr)
        `MSF_OFF_OPERATION_CONTROL:  next_s.rdata = s.operation_control;
        `MSF_OFF_CHAN:  next_s.rdata = s.chan;
        `MSF_OFF_RATIO: next_s.rdata = s.ratio;
        `MSF_OFF_MASK:  next_s.rdata = s.mask;
        `MSF_OFF_PTR:   next_s.rdata = 16'({s.wr_ptr, s.rd_ptr});
        `MSF_OFF_POP:
        begin
          next_s.hold  = pop_word;
          next_s.rdata = pop_word[47:32];
        end
        `MSF_OFF_HOLD1: next_s.rdata = s.hold[31:16];
        `MSF_OFF_HOLD2: next_s.rdata = s.hold[15:0];
        `MSF_OFF_STAT:  next_s.rdata = {12'h000, s.f_full, s.f_empty, s.f_thr, s.f_done};
        default:        next_s.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      s <= RST;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign reg_rdata  = s.rdata;
  assign conv_req   = s.req;
  assign comp_start = s.comp;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  chk_off_ptrs_zero: assert property (!q_on |=> s.rd_ptr == '0 && s.wr_ptr == '0)
    else $error("pointers not cleared in off mode");

  chk_stop_full_drop: assert property (q_stop && s.cnt == CAP_STOP && conv_done && !pop
    |=> s.cnt == CAP_STOP && $stable(s.wr_ptr))
    else $error("full queue accepted a sample");

  chk_ovwr_both_move: assert property (q_ovwr && s.cnt == CAP_OVWR && any_conv && !pop
    |=> s.rd_ptr == $past(s.rd_ptr) + PW'(1) && s.wr_ptr == $past(s.wr_ptr) + PW'(1))
    else $error("overwrite did not advance both pointers");

  chk_ovwr_cap: assert property (q_ovwr && s.cnt <= CAP_OVWR |=> s.cnt <= CAP_OVWR)
    else $error("overwrite mode exceeded its capacity");

  chk_pop_advance: assert property (pop && q_on && s.cnt != '0 && !over
    |=> s.rd_ptr == $past(s.rd_ptr) + PW'(1) && reg_rdata == $past(mif.rd_data[47:32]))
    else $error("sample read did not advance pointer");

  chk_cfg_locked: assert property (auto_on && reg_wr && reg_addr == `MSF_OFF_CHAN
    |=> $stable(s.chan))
    else $error("configuration changed in automatic mode");

  chk_flags_at_conv: assert property (!conv_done |=> $stable(s.f_empty) && $stable(s.f_full))
    else $error("queue flag moved outside conversion end");

  chk_thr_event: assert property (conv_done && thr != 5'h00 && next_s.cnt >= (PW+1)'(thr)
    |=> s.f_thr)
    else $error("threshold event missed");

  chk_alloff_empty: assert property (&ch_off && q_on && !pop |=> $stable(s.wr_ptr))
    else $error("write with all channels disabled");

  chk_comp_after: assert property (auto_on && any_conv |=> comp_start ##1 !comp_start)
    else $error("compensation start not one pulse");

  chk_read_window: assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data outside its cycle");

  cov_stop_full:  cover property (q_stop && s.f_full ##1 pop);
  cov_ovwr_wrap:  cover property (over);
  cov_thr_hit:    cover property ($rose(s.f_thr));
  cov_auto_pair:  cover property (auto_on && conv_done && ch_fresh == 3'b001);

endmodule

/* common/msf_cfg.svh */
`ifndef MSF_CFG_SVH
`define MSF_CFG_SVH

// ----------------------------------------
// Queue geometry
// ----------------------------------------
`define MSF_DEPTH       32
`define MSF_ENTRY_W     48

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define MSF_OFF_CHAN    8'h60
`define MSF_OFF_RATIO   8'h61
`define MSF_OFF_MASK    8'h62
`define MSF_OFF_OPERATION_CONTROL    8'h64
`define MSF_OFF_PTR     8'h65
`define MSF_OFF_POP     8'h66
`define MSF_OFF_HOLD1   8'h67
`define MSF_OFF_HOLD2   8'h68
`define MSF_OFF_STAT    8'h80

// ----------------------------------------
// Field positions
// ----------------------------------------
`define MSF_OPERATION_CONTROL_DLY    0
`define MSF_OPERATION_CONTROL_MODE   4
`define MSF_OPERATION_CONTROL_THR    6
`define MSF_OPERATION_CONTROL_SELT   11
`define MSF_CHAN_RAW    3
`define MSF_CHAN_IIR    4
`define MSF_STAT_DONE   0
`define MSF_STAT_THR    1
`define MSF_STAT_EMPTY  2
`define MSF_STAT_FULL   3

// ----------------------------------------
// Reset values and substitution codes
// ----------------------------------------
`define MSF_RST_OPERATION_CONTROL    16'h0000
`define MSF_RST_CHAN    16'h0000
`define MSF_RST_RATIO   16'h0111
`define MSF_RST_MASK    16'h0000
`define MSF_ERR_BRIDGE  24'h800001
`define MSF_ERR_OVFL    24'h7FFFFF
`define MSF_ERR_UDFL    24'h800000

`endif

/* common/msf_pkg.sv */
package msf_pkg;

  typedef logic [23:0] msf_word_t;

  typedef enum logic [1:0]
  {
    MSF_Q_OFF  = 2'b00,
    MSF_Q_STOP = 2'b01,
    MSF_Q_OVWR = 2'b10
  } msf_qmode_t;

endpackage

/* common/msf_if.sv */
`timescale 1ns/1ps

interface msf_if #(
  parameter int AW = 5,
  parameter int DW = 48
);
  logic          wr_en;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;
  logic [AW-1:0] rd_addr;
  logic [DW-1:0] rd_data;

  modport ctl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

/* logic/msf_store.sv */
`timescale 1ns/1ps
`include "msf_cfg.svh"

module msf_store #(
  parameter int DEPTH = `MSF_DEPTH,
  parameter int DW    = `MSF_ENTRY_W
)(
  input wire logic ref_clk,
  input wire logic rstn,
  msf_if.mem       port
);

  typedef struct packed
  {
    logic [DEPTH-1:0][DW-1:0] mem;
  } msf_store_t;

  msf_store_t s;
  msf_store_t next_s;

  always_comb
  begin
    next_s = s;
    if (port.wr_en)
    begin
      next_s.mem[port.wr_addr] = port.wr_data;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  // Asynchronous read keeps the pop answer within one cycle
  assign port.rd_data = s.mem[port.rd_addr];

endmodule

/* verif/msf_conv_model.sv */
`timescale 1ns/1ps

// ----------------------------------------
// Sequencer and converter stand-in
// ----------------------------------------
module msf_conv_model (
  input  wire logic                     ref_clk,
  input  wire logic                     rstn,
  input  wire logic                     go,
  input  wire logic [2:0]               force_valid,
  input  wire logic [2:0]               p_err,
  input  wire logic [3:0]               lat,
  input  wire logic [2:0]               conv_req,
  output logic                          cycle_tick,
  output logic                          conv_done,
  output logic      [2:0]               res_valid,
  output msf_pkg::msf_word_t [2:0]      res_raw,
  output msf_pkg::msf_word_t [2:0]      res_cmp,
  output logic      [2:0][2:0]          res_err
);
  logic [7:0] seq;
  logic [2:0] req;

  function automatic msf_pkg::msf_word_t word(input int c, input logic [7:0] n, input logic cmp);
    return {4'(1 + c + (cmp ? 4 : 0)), 10'h000, n, 2'b00};
  endfunction

  initial
  begin
    cycle_tick = 1'b0;
    conv_done  = 1'b0;
    res_valid  = 3'b000;
    res_raw    = '0;
    res_cmp    = '0;
    res_err    = '0;
    seq        = 8'h00;
    req        = 3'b000;
  end

  always
  begin
    @(posedge ref_clk);
    if (go === 1'b1 && rstn === 1'b1)
    begin
      cycle_tick <= 1'b1;
      @(posedge ref_clk);
      cycle_tick <= 1'b0;
      @(posedge ref_clk);
      req = conv_req;
      repeat (lat) @(posedge ref_clk);
      conv_done <= 1'b1;
      res_valid <= req | force_valid;
      for (int c = 0; c < 3; c++)
      begin
        res_raw[c] <= word(c, seq, 1'b0);
        res_cmp[c] <= word(c, seq, 1'b1);
      end
      res_err <= {6'h00, p_err};
      @(posedge ref_clk);
      conv_done <= 1'b0;
      res_valid <= 3'b000;
      // Results are stale now, so show garbage rather than the last word
      res_raw   <= ~res_raw;
      res_cmp   <= ~res_cmp;
      res_err   <= ~res_err;
      seq       <= seq + 8'h01;
    end
  end
endmodule

/* verif/measurement_sample_fifo_tb.sv */
`timescale 1ns/1ps
`include "msf_cfg.svh"

module measurement_sample_fifo_tb;
  logic                     ref_clk;
  logic                     rstn;
  logic [7:0]               reg_addr;
  logic [15:0]              reg_wdata;
  logic                     reg_wr;
  logic                     reg_rd;
  logic [15:0]              reg_rdata;
  logic                     cycle_tick;
  logic                     conv_done;
  logic [2:0]               res_valid;
  msf_pkg::msf_word_t [2:0] res_raw;
  msf_pkg::msf_word_t [2:0] res_cmp;
  logic [2:0][2:0]          res_err;
  logic [2:0]               conv_req;
  logic                     comp_start;
  logic                     go;
  logic [2:0]               fv;
  logic [2:0]               perr;
  logic [3:0]               lat;
  logic [15:0]              d;
  logic [47:0]              e;
  int                       bad_count;
  int                       tests_run;
  int                       nconv;
  int                       comp_n;
  int                       base;

  msf_top dut (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cycle_tick(cycle_tick), .conv_done(conv_done),
    .res_valid(res_valid), .res_raw(res_raw), .res_cmp(res_cmp), .res_err(res_err), .conv_req(conv_req),
    .comp_start(comp_start));

  msf_conv_model conv (.ref_clk(ref_clk), .rstn(rstn), .go(go), .force_valid(fv), .p_err(perr), .lat(lat),
    .conv_req(conv_req), .cycle_tick(cycle_tick), .conv_done(conv_done), .res_valid(res_valid),
    .res_raw(res_raw), .res_cmp(res_cmp), .res_err(res_err));

  always #25 ref_clk = ~ref_clk;

  always @(posedge ref_clk)
    if (comp_start === 1'b1)
      comp_n++;

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [47:0] seen, input logic [47:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    @(negedge ref_clk);
    v = reg_rdata;
    @(posedge ref_clk);
  endtask

  task automatic rchk(input string what, input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] v;
    rd(a, v);
    chk(what, {32'h0, v}, {32'h0, exp});
  endtask

  // Skipping the two follow-up reads loses the entry
  task automatic pop(output logic [47:0] ent);
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] c;
    rd(`MSF_OFF_POP, a);
    rd(`MSF_OFF_HOLD1, b);
    rd(`MSF_OFF_HOLD2, c);
    ent = {a, b, c};
  endtask

  task automatic run_conv(input logic [2:0] v, input logic [2:0] pe);
    int k;
    fv   <= v;
    perr <= pe;
    go   <= 1'b1;
    @(posedge ref_clk);
    go   <= 1'b0;
    k = 0;
    while (conv_done !== 1'b1 && k < 20)
    begin
      @(posedge ref_clk);
      k++;
    end
    @(posedge ref_clk);
    nconv++;
  endtask

  function automatic logic [23:0] word(input int c, input int n, input logic cmp);
    return {4'(1 + c + (cmp ? 4 : 0)), 10'h000, 8'(n), 2'b00};
  endfunction

  task automatic give_verdict;
    if (bad_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    give_verdict();
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial
  begin
    ref_clk = 1'b0;
    rstn = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    go = 1'b0;
    fv = 3'b000;
    perr = 3'b000;
    lat = 4'h1;
    bad_count = 0;
    tests_run = 0;
    nconv = 0;
    comp_n = 0;
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    rchk("operation_control", `MSF_OFF_OPERATION_CONTROL, `MSF_RST_OPERATION_CONTROL);
    rchk("ratio", `MSF_OFF_RATIO, `MSF_RST_RATIO);
    rchk("mask", `MSF_OFF_MASK, `MSF_RST_MASK);
    rchk("status", `MSF_OFF_STAT, 16'h0004);
    rchk("unmapped", 8'h70, 16'h0000);
    run_conv(3'b011, 3'b000);
    rchk("ptr off", `MSF_OFF_PTR, 16'h0000);
    // Stop mode, raw words, threshold 5
    wr(`MSF_OFF_CHAN, 16'h0008);
    wr(`MSF_OFF_OPERATION_CONTROL, 16'h0150);
    base = nconv;
    for (int n = 0; n < 33; n++)
    begin
      run_conv(3'b011, 3'b000);
      if (n == 3 || n == 4)
      begin
        rd(`MSF_OFF_STAT, d);
        chk("thr flag", d[1], n == 4);
      end
    end
    rd(`MSF_OFF_STAT, d);
    chk("full thr", d[3:1], 3'b101);
    wr(`MSF_OFF_STAT, 16'h0003);
    rchk("flags cleared", `MSF_OFF_STAT, 16'h0008);
    for (int n = 0; n < 32; n++)
    begin
      pop(e);
      chk("stop entry", e, {word(1, base + n, 0), word(0, base + n, 0)});
    end
    pop(e);
    chk("stop drop", e[47:32], 16'h0000);
    // Overwrite mode 11, second temperature, filtered values
    wr(`MSF_OFF_OPERATION_CONTROL, 16'h0000);
    rchk("ptr cleared", `MSF_OFF_PTR, 16'h0000);
    wr(`MSF_OFF_CHAN, 16'h0010);
    wr(`MSF_OFF_OPERATION_CONTROL, 16'h0830);
    base = nconv;
    for (int n = 0; n < 33; n++)
      run_conv(3'b101, 3'b000);
    for (int n = 0; n < 31; n++)
    begin
      pop(e);
      chk("ovwr entry", e, {word(2, base + 2 + n, 1), word(0, base + 2 + n, 1)});
    end
    pop(e);
    chk("ovwr empty", e[47:32], 16'h0000);
    // All channels off, then stale slot and error codes
    wr(`MSF_OFF_OPERATION_CONTROL, 16'h0000);
    wr(`MSF_OFF_CHAN, 16'h0007);
    wr(`MSF_OFF_OPERATION_CONTROL, 16'h0010);
    run_conv(3'b111, 3'b000);
    rchk("ptr all off", `MSF_OFF_PTR, 16'h0000);
    wr(`MSF_OFF_CHAN, 16'h0008);
    base = nconv;
    run_conv(3'b111, 3'b000);
    wr(`MSF_OFF_CHAN, 16'h000A);
    for (int i = 0; i < 4; i++)
    begin
      if (i == 3)
        wr(`MSF_OFF_MASK, 16'h0001);
      run_conv(3'b111, (i == 3) ? 3'b001 : 3'(1 << i));
    end
    pop(e);
    chk("fresh pair", e, {word(1, base, 0), word(0, base, 0)});
    pop(e);
    chk("bridge code", e, {word(1, base, 0), `MSF_ERR_BRIDGE});
    pop(e);
    chk("ovfl code", e, {word(1, base, 0), `MSF_ERR_OVFL});
    pop(e);
    chk("udfl code", e, {word(1, base, 0), `MSF_ERR_UDFL});
    pop(e);
    chk("masked", e, {word(1, base, 0), word(0, base + 4, 0)});
    // Off mode answers with the latest pair, no error codes
    wr(`MSF_OFF_OPERATION_CONTROL, 16'h0000);
    run_conv(3'b111, 3'b010);
    pop(e);
    chk("off pop", e, {word(1, base, 0), word(0, base + 5, 0)});
    // Automatic mode, pressure every 2nd and t1 every 4th cycle
    wr(`MSF_OFF_MASK, 16'h0000);
    wr(`MSF_OFF_CHAN, 16'h000C);
    wr(`MSF_OFF_RATIO, 16'h0142);
    wr(`MSF_OFF_OPERATION_CONTROL, 16'h0021);
    wr(`MSF_OFF_CHAN, 16'h0000);
    rchk("locked chan", `MSF_OFF_CHAN, 16'h000C);
    lat <= 4'h6;
    comp_n = 0;
    base = nconv;
    for (int n = 0; n < 8; n++)
      run_conv(3'b000, 3'b000);
    chk("comp starts", 48'(comp_n), 48'h4);
    rchk("auto ptr", `MSF_OFF_PTR, 16'h0080);
    for (int k = 0; k < 4; k++)
    begin
      pop(e);
      chk("auto entry", e, {word(1, base + 4 * (k / 2), 0), word(0, base + 2 * k, 0)});
    end
    give_verdict();
  end
endmodule
